// >>> rtl/anx_pkg.sv
// Package for the auto-negotiation expansion, next page and indirect
// MMD access registers. Assumes a 16-bit management register port.
package anx_pkg;
  // Register addresses on the management port
  localparam logic [4:0] ADDR_EXP = 5'h06;
  localparam logic [4:0] ADDR_TXNP = 5'h07;
  localparam logic [4:0] ADDR_RXNP = 5'h08;
  localparam logic [4:0] ADDR_CTL = 5'h0d;
  localparam logic [4:0] ADDR_WIN = 5'h0e;
  // Expansion bit positions
  localparam int EXP_PDF = 4;
  localparam int EXP_LPNP = 3;
  localparam int EXP_NPA = 2;
  localparam int EXP_PRX = 1;
  localparam int EXP_LPAN = 0;
  // Next page word bit positions (transmit and receive share layout)
  localparam int NP_MORE = 15;
  localparam int NP_ACK = 14;
  localparam int NP_MSG = 13;
  localparam int NP_ACK2 = 12;
  localparam int NP_TOG = 11;
  localparam int NP_FLD_W = 11;
  // Control register fields
  localparam int CTL_OP_LSB = 14;
  localparam int CTL_RSV_LSB = 5;
  localparam int CTL_RSV_W = 9;
  localparam int CTL_DEV_W = 5;
  // Reset values
  localparam logic NP_MSG_RST = 1'h1;
  localparam logic [10:0] NP_FLD_RST = 11'h001;
  localparam logic NPA_RST = 1'h1;
  // Operation selector codes
  typedef enum logic [1:0] {
    ANX_OP_REG = 2'h0,
    ANX_OP_DATA = 2'h1,
    ANX_OP_INC_RW = 2'h2,
    ANX_OP_INC_W = 2'h3
  } anx_op_e;
  // Received next page word
  typedef struct packed {
    logic more;
    logic ack;
    logic msg;
    logic ack2;
    logic toggle;
    logic [10:0] field;
  } anx_page_s;
  // Whole block state
  typedef struct packed {
    logic pd_fault;
    logic page_rx;
    logic lp_np;
    logic lp_an;
    logic tx_more;
    logic tx_msg;
    logic tx_ack2;
    logic tx_toggle;
    logic [10:0] tx_field;
    logic tx_load;
    anx_page_s lp_page;
    anx_op_e op;
    logic [8:0] ctl_rsvd;
    logic [4:0] dev;
    logic [15:0] ptr;
    logic [15:0] rdata;
    logic rvalid;
    logic mmd_wr;
    logic mmd_rd;
    logic [15:0] mmd_wdata;
  } anx_state_s;
endpackage : anx_pkg

// >>> rtl/anx_regs.sv
// Auto-negotiation expansion, local and partner next page, and the
// indirect MMD window. Assumes the management framer, negotiation
// engine and MMD store all run on this clock.
//
// What this block does
// R1: Parallel detection fault bit sets on a fault and latches until read.
// R2: Expansion bit reports whether the partner is next page capable.
// R3: Expansion bit shows local next page capability, one from reset.
// R4: Page received bit latches high on a new page, else zero.
// R5: Expansion bit shows partner auto-negotiation ability, reset zero.
// R6: Software writes more-pages and message-page bits; both are sent.
// R7: Software writes second-acknowledge for the transmitted page, reset zero.
// R8: Read-only toggle bit mirrors the previous transmitted toggle.
// R9: Writable 11-bit message field, reset value one.
// R10: Received next page captured read-only, all fields reset zero.
// R11: Partner second-acknowledge bit shown read-only.
// R12: Partner toggle bit shown read-only as received.
// R13: Two-bit selector picks address, data, or post-increment data modes.
// R14: Five-bit MMD device address field, writable, reset zero.
// R15: Selector zero makes the window access the register address pointer.
// R16: Non-zero selector makes the window move MMD data at the pointer.
// R17: Latch-high bits hold until read; self-cleared bits clear alone.
// R18: Post-increment advances the pointer by one after qualifying access.
// R19: Controller sets device, then address, then data mode, then data.
`timescale 1ns/100ps
module anx_regs (
  input wire logic clock,
  input wire logic nrst,
  // Management register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Negotiation engine
  input wire logic pd_fault_evt,
  input wire logic lp_np_able,
  input wire logic lp_an_able,
  input wire logic page_rx_evt,
  input wire logic [15:0] page_rx_word,
  input wire logic tx_toggle_prev,
  output logic [15:0] tx_page_word,
  output logic tx_page_load,
  // MMD store
  output logic [4:0] mmd_dev,
  output logic [15:0] mmd_addr,
  output logic [15:0] mmd_wdata,
  output logic mmd_wr,
  output logic mmd_rd,
  input wire logic [15:0] mmd_rdata
);

  anx_pkg::anx_state_s st_r;
  anx_pkg::anx_state_s st_nxt;

  // Read mux for the read strobe; unmapped addresses read as zero
  function automatic logic [15:0] anx_read(
    input anx_pkg::anx_state_s s,
    input logic [4:0] a,
    input logic [15:0] mdata
  );
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      anx_pkg::ADDR_EXP: begin
        v[anx_pkg::EXP_PDF] = s.pd_fault;
        v[anx_pkg::EXP_LPNP] = s.lp_np;
        v[anx_pkg::EXP_NPA] = anx_pkg::NPA_RST; // R3
        v[anx_pkg::EXP_PRX] = s.page_rx;
        v[anx_pkg::EXP_LPAN] = s.lp_an;
      end
      anx_pkg::ADDR_TXNP: begin
        v = {s.tx_more, 1'h0, s.tx_msg, s.tx_ack2, s.tx_toggle, s.tx_field};
      end
      anx_pkg::ADDR_RXNP: v = s.lp_page;
      anx_pkg::ADDR_CTL: v = {s.op, s.ctl_rsvd, s.dev};
      anx_pkg::ADDR_WIN: v = (s.op == anx_pkg::ANX_OP_REG) ? s.ptr : mdata;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : anx_read

  // Next-state logic; hardware sets are applied after read clears
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0; // R17
    st_nxt.mmd_wr = 1'b0;
    st_nxt.mmd_rd = 1'b0;
    st_nxt.tx_load = 1'b0;
    st_nxt.lp_np = lp_np_able; // R2
    st_nxt.lp_an = lp_an_able; // R5
    st_nxt.tx_toggle = tx_toggle_prev; // R8
    if (reg_rd) begin
      st_nxt.rdata = anx_read(st_r, reg_addr, mmd_rdata);
      st_nxt.rvalid = 1'b1;
      // Reading the expansion register clears its latched bits
      if (reg_addr == anx_pkg::ADDR_EXP) begin
        st_nxt.pd_fault = 1'b0; // R1
        st_nxt.page_rx = 1'b0; // R4
      end
      if (reg_addr == anx_pkg::ADDR_WIN && st_r.op != anx_pkg::ANX_OP_REG) begin
        st_nxt.mmd_rd = 1'b1; // R16
        if (st_r.op == anx_pkg::ANX_OP_INC_RW) begin
          st_nxt.ptr = st_r.ptr + 16'h0001; // R18
        end
      end
    end else if (reg_wr) begin
      case (reg_addr)
        anx_pkg::ADDR_TXNP: begin
          st_nxt.tx_more = reg_wdata[anx_pkg::NP_MORE]; // R6
          st_nxt.tx_msg = reg_wdata[anx_pkg::NP_MSG]; // R6
          st_nxt.tx_ack2 = reg_wdata[anx_pkg::NP_ACK2]; // R7
          st_nxt.tx_field = reg_wdata[anx_pkg::NP_FLD_W-1:0]; // R9
          st_nxt.tx_load = 1'b1;
        end
        anx_pkg::ADDR_CTL: begin
          st_nxt.op = anx_pkg::anx_op_e'(reg_wdata[15:anx_pkg::CTL_OP_LSB]); // R13
          st_nxt.ctl_rsvd = reg_wdata[anx_pkg::CTL_RSV_LSB +: anx_pkg::CTL_RSV_W];
          st_nxt.dev = reg_wdata[anx_pkg::CTL_DEV_W-1:0]; // R14
        end
        anx_pkg::ADDR_WIN: begin
          if (st_r.op == anx_pkg::ANX_OP_REG) begin
            st_nxt.ptr = reg_wdata; // R15
          end else begin
            st_nxt.mmd_wr = 1'b1; // R16
            st_nxt.mmd_wdata = reg_wdata;
            // Both increment modes advance after a write
            if (st_r.op[1]) begin
              st_nxt.ptr = st_r.ptr + 16'h0001; // R18
            end
          end
        end
        default: begin
          // Read-only and unmapped addresses ignore writes
        end
      endcase
    end
    // Event sets win over a read clear in the same cycle
    if (pd_fault_evt) begin
      st_nxt.pd_fault = 1'b1; // R1
    end
    if (page_rx_evt) begin
      st_nxt.page_rx = 1'b1; // R4
      st_nxt.lp_page = page_rx_word; // R10 R11 R12
    end
  end

  // State register; reset values are constants only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.tx_msg <= anx_pkg::NP_MSG_RST; // R6
      st_r.tx_field <= anx_pkg::NP_FLD_RST; // R9
      st_r.op <= anx_pkg::ANX_OP_REG;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register
  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign tx_page_word = {st_r.tx_more, 1'h0, st_r.tx_msg, st_r.tx_ack2,
    st_r.tx_toggle, st_r.tx_field}; // R6
  assign tx_page_load = st_r.tx_load;
  assign mmd_dev = st_r.dev;
  assign mmd_addr = st_r.ptr;
  assign mmd_wdata = st_r.mmd_wdata;
  assign mmd_wr = st_r.mmd_wr;
  assign mmd_rd = st_r.mmd_rd;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_pdf_latch;
    pd_fault_evt |=> st_r.pd_fault;
  endproperty
  a_pdf_latch: assert property (p_pdf_latch) else $error("fault not latched"); // R1

  property p_pdf_hold;
    st_r.pd_fault && !(reg_rd && reg_addr == anx_pkg::ADDR_EXP) |=> st_r.pd_fault;
  endproperty
  a_pdf_hold: assert property (p_pdf_hold) else $error("fault lost unread"); // R17

  property p_prx_read;
    reg_rd && reg_addr == anx_pkg::ADDR_EXP && !page_rx_evt
      |=> reg_rvalid && reg_rdata[anx_pkg::EXP_PRX] == $past(st_r.page_rx)
      && !st_r.page_rx;
  endproperty
  a_prx_read: assert property (p_prx_read) else $error("page rx read bad"); // R4

  property p_npa;
    reg_rd && reg_addr == anx_pkg::ADDR_EXP |=> reg_rdata[anx_pkg::EXP_NPA];
  endproperty
  a_npa: assert property (p_npa) else $error("next page able not one"); // R3

  property p_lp_levels;
    ##1 st_r.lp_np == $past(lp_np_able) && st_r.lp_an == $past(lp_an_able);
  endproperty
  a_lp_levels: assert property (p_lp_levels) else $error("partner level"); // R2

  property p_rx_page;
    page_rx_evt |=> st_r.lp_page == $past(page_rx_word);
  endproperty
  a_rx_page: assert property (p_rx_page) else $error("page not captured"); // R10

  property p_txnp_wr;
    reg_wr && !reg_rd && reg_addr == anx_pkg::ADDR_TXNP
      |=> tx_page_load && tx_page_word[15] == $past(reg_wdata[15])
      && !tx_page_word[14]
      && tx_page_word[13:12] == $past(reg_wdata[13:12])
      && tx_page_word[10:0] == $past(reg_wdata[10:0]);
  endproperty
  a_txnp_wr: assert property (p_txnp_wr) else $error("tx page write"); // R9

  property p_ptr_wr;
    reg_wr && !reg_rd && reg_addr == anx_pkg::ADDR_WIN
      && st_r.op == anx_pkg::ANX_OP_REG |=> mmd_addr == $past(reg_wdata) && !mmd_wr;
  endproperty
  a_ptr_wr: assert property (p_ptr_wr) else $error("pointer write"); // R15

  property p_data_wr;
    reg_wr && !reg_rd && reg_addr == anx_pkg::ADDR_WIN
      && st_r.op != anx_pkg::ANX_OP_REG
      |=> mmd_wr && mmd_wdata == $past(reg_wdata) && mmd_dev == $past(st_r.dev);
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("mmd write"); // R16

  property p_inc_rd;
    reg_rd && reg_addr == anx_pkg::ADDR_WIN
      |=> mmd_addr == $past(st_r.ptr)
      + (($past(st_r.op) == anx_pkg::ANX_OP_INC_RW) ? 16'h0001 : 16'h0000);
  endproperty
  a_inc_rd: assert property (p_inc_rd) else $error("read increment"); // R18

  property p_ctl_wr;
    reg_wr && !reg_rd && reg_addr == anx_pkg::ADDR_CTL
      |=> st_r.op == $past(reg_wdata[15:14]) && mmd_dev == $past(reg_wdata[4:0]);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("control write"); // R13

endmodule : anx_regs

// >>> verification/anx_mmd_model.sv
// Behavioural MMD store standing behind the indirect window.
// Assumes mmd_wr comes a cycle after the strobe, pointer maybe bumped.
`timescale 1ns/100ps
module anx_mmd_model (
  input wire logic clock,
  input wire logic [15:0] mmd_addr,
  input wire logic [15:0] mmd_wdata,
  input wire logic mmd_wr,
  output logic [15:0] mmd_rdata
);
  logic [15:0] mem [256];
  logic [15:0] addr_q;
  // Cleared so that reads of unwritten places are defined
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // Write target is the pointer seen in the strobe cycle, not the bumped one
  always @(posedge clock) begin
    addr_q <= mmd_addr;
    if (mmd_wr) mem[addr_q[7:0]] <= mmd_wdata;
  end
  // Same-cycle read; only 256 places are kept, device is ignored
  assign mmd_rdata = mem[mmd_addr[7:0]];
endmodule : anx_mmd_model

// >>> verification/test_anx_regs.sv
// Self-checking bench for the expansion, next page and MMD window.
// Assumes the MMD store model file is compiled first.
`timescale 1ns/100ps
module test_anx_regs;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, tx_page_word, mmd_addr, mmd_wdata, mmd_rdata;
  logic reg_rvalid, mmd_wr, tx_page_load, mmd_rd;
  logic pd_fault_evt = 1'b0;
  logic lp_np_able = 1'b0;
  logic lp_an_able = 1'b0;
  logic page_rx_evt = 1'b0;
  logic [15:0] page_rx_word = 16'h0000;
  logic tx_toggle_prev = 1'b0;
  logic [4:0] mmd_dev, dev;
  logic [15:0] bptr, pw, w, e, d;
  logic [15:0] bmem [256];
  logic [1:0] op;
  logic np, an;
  logic [7:0] base;
  int seed, err_total, n_tests;
  anx_regs dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pd_fault_evt(pd_fault_evt), .lp_np_able(lp_np_able),
    .lp_an_able(lp_an_able), .page_rx_evt(page_rx_evt),
    .page_rx_word(page_rx_word), .tx_toggle_prev(tx_toggle_prev),
    .tx_page_word(tx_page_word), .tx_page_load(tx_page_load),
    .mmd_dev(mmd_dev), .mmd_addr(mmd_addr), .mmd_wdata(mmd_wdata),
    .mmd_wr(mmd_wr), .mmd_rd(mmd_rd), .mmd_rdata(mmd_rdata));
  anx_mmd_model mmd (.clock(clock), .mmd_addr(mmd_addr),
    .mmd_wdata(mmd_wdata), .mmd_wr(mmd_wr), .mmd_rdata(mmd_rdata));
  // 250 MHz clock
  always #2 clock = ~clock;
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One-cycle strobes, launched on the falling edge
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [15:0] x);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk("rvalid", {15'h0000, reg_rvalid}, 16'h0001);
    chk("rdata", reg_rdata, x);
  endtask : rc
  task automatic setop(input logic [1:0] o);
    op = o;
    wr(anx_pkg::ADDR_CTL, {o, 9'h000, dev});
    rc(anx_pkg::ADDR_CTL, {o, 9'h000, dev});
    chk("mmd_dev", {11'h000, mmd_dev}, {11'h000, dev});
  endtask : setop
  // Window accesses mirrored in the reference pointer and store
  task automatic mwr(input logic [15:0] v);
    wr(anx_pkg::ADDR_WIN, v);
    if (op == 2'h0) bptr = v;
    else begin
      bmem[bptr[7:0]] = v;
      if (op[1]) bptr++;
      chk("mmd_wdata", mmd_wdata, v);
    end
    // The write pulse stands for one cycle after the strobe
    chk("mmd_wr", {15'h0000, mmd_wr}, {15'h0000, op != 2'h0});
    chk("mmd_addr", mmd_addr, bptr);
  endtask : mwr
  task automatic mrd();
    rc(anx_pkg::ADDR_WIN, op == 2'h0 ? bptr : bmem[bptr[7:0]]);
    if (op == 2'h2) bptr++;
    chk("mmd_rd", {15'h0000, mmd_rd}, {15'h0000, op != 2'h0});
    chk("mmd_addr", mmd_addr, bptr);
  endtask : mrd
  // Cut a hang short well past the expected run length
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
  initial begin
    seed = 9;
    bptr = 16'h0000;
    foreach (bmem[i]) bmem[i] = 16'h0000;
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    rc(anx_pkg::ADDR_EXP, 16'h0004);
    rc(anx_pkg::ADDR_TXNP, 16'h2001);
    rc(anx_pkg::ADDR_RXNP, 16'h0000);
    rc(anx_pkg::ADDR_CTL, 16'h0000);
    rc(anx_pkg::ADDR_WIN, 16'h0000);
    rc(5'h1f, 16'h0000);
    $display("reset test done");
    // Events pulse once; status levels are random
    {np, an} = 2'($random(seed));
    pw = 16'($random(seed));
    @(negedge clock);
    lp_np_able = np;
    lp_an_able = an;
    pd_fault_evt = 1'b1;
    page_rx_evt = 1'b1;
    page_rx_word = pw;
    @(negedge clock);
    pd_fault_evt = 1'b0;
    page_rx_evt = 1'b0;
    rc(anx_pkg::ADDR_EXP, {11'h000, 1'b1, np, 2'h3, an});
    rc(anx_pkg::ADDR_EXP, {11'h000, 1'b0, np, 2'h2, an});
    wr(anx_pkg::ADDR_RXNP, ~pw);
    wr(anx_pkg::ADDR_EXP, 16'hffff);
    rc(anx_pkg::ADDR_RXNP, pw);
    rc(anx_pkg::ADDR_EXP, {11'h000, 1'b0, np, 2'h2, an});
    // Fault during a clearing read: old value read, but the set must win
    @(negedge clock);
    reg_addr = anx_pkg::ADDR_EXP;
    reg_rd = 1'b1;
    pd_fault_evt = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    pd_fault_evt = 1'b0;
    chk("rdata", reg_rdata, {11'h000, 1'b0, np, 2'h2, an});
    rc(anx_pkg::ADDR_EXP, {11'h000, 1'b1, np, 2'h2, an});
    $display("status test done");
    // Written page comes back with reserved zero and live toggle
    w = 16'($random(seed));
    tx_toggle_prev = 1'b1;
    wr(anx_pkg::ADDR_TXNP, w);
    chk("tx_page_load", {15'h0000, tx_page_load}, 16'h0001);
    e = (w & 16'hb7ff) | 16'h0800;
    rc(anx_pkg::ADDR_TXNP, e);
    chk("tx_page_word", tx_page_word, e);
    $display("page test done");
    // Every data mode: set pointer, two writes, pointer, two reads
    dev = 5'($random(seed));
    for (int k = 1; k < 4; k++) begin
      base = 8'($random(seed)) & 8'hf0;
      setop(2'h0);
      mwr({8'h00, base});
      mrd();
      setop(2'(k));
      d = 16'($random(seed));
      mwr(d);
      d = 16'($random(seed));
      mwr(d);
      setop(2'h0);
      mrd();
      mwr({8'h00, base});
      setop(2'(k));
      mrd();
      mrd();
    end
    $display("window test done");
    report_and_stop();
  end
endmodule : test_anx_regs
